// >>> rtl/fbwc_top.sv
// serial command front end for buffer write and program commands
// Operation
// - buffer write codes 0x84 selects buffer one, 0x87 buffer two.
// - program with erase codes 0x83 buffer one, 0x86 buffer two.
// - program without erase codes 0x88 buffer one, 0x89 buffer two.
// - program through buffer 0x82 and 0x85 write buffer then erase-program.
// - compare codes 0x60 and 0x61 write nothing.
// - auto rewrite codes 0x58 and 0x59, with erase, write nothing to the buffer.
// - single buffer variant rejects every second buffer code.
// - 24-bit address follows; buffer write uses only byte position within buffer, op_addr_o carries all 24 bits.
// - data bytes follow the address msb first, captured serially.
// - first byte at start address, pointer increments per further byte.
// - pointer past last location wraps to first location.
// - buffer write touches only the selected buffer, never the array.
// - ready bit 7 low while page program runs, high when done.
module fbwc_top
  import fbwc_pkg::*;
#(
  parameter int DEPTH       = fbwc_pkg::FBWC_BUF_DEPTH,
  parameter int NBUF        = fbwc_pkg::FBWC_NUM_BUF,
  parameter int PEP_CYCLES  = fbwc_pkg::FBWC_PEP_CYCLES,
  parameter int PP_CYCLES   = fbwc_pkg::FBWC_PP_CYCLES,
  parameter int AW          = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  // serial link
  input  wire logic                          spi_clk_i,
  input  wire logic                          chip_select_low_i,
  input  wire logic                          mosi_i,
  output logic                               miso_o,
  // status
  output logic      [7:0]                    status_o,
  // array operation request
  output logic                               op_valid_o,
  output fbwc_pkg::fbwc_op_t                 op_kind_o,
  output logic                               op_buf_o,
  output logic      [fbwc_pkg::FBWC_ADDR_W-1:0] op_addr_o,
  // buffer read for the array
  input  wire logic                          rd_sel_i,
  input  wire logic [AW-1:0]                 rd_addr_i,
  output logic      [7:0]                    rd_data_o
);

  import fbwc_pkg::*;

  localparam int CW = $clog2(PEP_CYCLES + 1);
  localparam logic [CW-1:0] PEP_LOAD = CW'(PEP_CYCLES);
  localparam logic [CW-1:0] PP_LOAD  = CW'(PP_CYCLES);
  localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  // ---------------------------------------------------------------
  // link sampling
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_q;
  logic       csn_q;
  wire        sclk_s = pins_s[2];
  wire        csn_s  = pins_s[1];
  wire        mosi_s = pins_s[0];

  fbwc_sync #(
    .W       (3),
    .RST_VAL (FBWC_SYNC_RST)
  ) u_sync (
    .clk_i   (sys_clk_i),
    .rst_ni  (resetn_i),
    .d_i     ({spi_clk_i, chip_select_low_i, mosi_i}),
    .q_o     (pins_s)
  );

  // master drives data on falling edges, so sample on rising edges
  wire sclk_rise = sclk_s & ~sclk_q;
  wire cs_fall   = ~csn_s & csn_q;
  wire cs_rise   = csn_s & ~csn_q;

  // ---------------------------------------------------------------
  // bit and byte assembly
  // ---------------------------------------------------------------
  fbwc_state_t state_q;
  fbwc_state_t state_d;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [1:0]  byte_cnt_q;
  logic [15:0] addr_hi_q;

  wire       shift_en  = sclk_rise & ~csn_s;
  wire [7:0] new_byte  = {shift_q[6:0], mosi_s};
  wire       byte_done = shift_en & (bit_cnt_q == FBWC_LAST_BIT);
  wire [FBWC_ADDR_W-1:0] full_addr = {addr_hi_q, new_byte};

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
    end
    else if (cs_fall)
    begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
    end
    else if (shift_en)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= new_byte;
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  fbwc_op_t dec_op;

  assign dec_op =
    (new_byte inside {FBWC_CMD_WR_B1,  FBWC_CMD_WR_B2})  ? FBWC_OP_BUF_WR     :
    (new_byte inside {FBWC_CMD_PEP_B1, FBWC_CMD_PEP_B2}) ? FBWC_OP_PROG_ERASE :
    (new_byte inside {FBWC_CMD_PP_B1,  FBWC_CMD_PP_B2})  ? FBWC_OP_PROG       :
    (new_byte inside {FBWC_CMD_PTB_B1, FBWC_CMD_PTB_B2}) ? FBWC_OP_PROG_THRU  :
    (new_byte inside {FBWC_CMD_CMP_B1, FBWC_CMD_CMP_B2}) ? FBWC_OP_COMPARE    :
    (new_byte inside {FBWC_CMD_RW_B1,  FBWC_CMD_RW_B2})  ? FBWC_OP_REWRITE    :
                                                           FBWC_OP_NONE;
  wire dec_buf = new_byte inside {FBWC_CMD_WR_B2,  FBWC_CMD_PEP_B2, FBWC_CMD_PP_B2,
                                  FBWC_CMD_PTB_B2, FBWC_CMD_CMP_B2, FBWC_CMD_RW_B2};

  wire buf_ok  = (NBUF > 1) | ~dec_buf;
  wire dec_ok  = (dec_op != FBWC_OP_NONE) & buf_ok;

  // ---------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------
  fbwc_op_t op_q;
  logic     buf_q;

  wire takes_data = (op_q == FBWC_OP_BUF_WR) | (op_q == FBWC_OP_PROG_THRU);
  wire addr_last  = byte_done & (byte_cnt_q == FBWC_LAST_ADDR);

  always_comb
  begin
    state_d = state_q;
    if (csn_s)
      state_d = FBWC_ST_IDLE;
    else if (cs_fall)
      state_d = FBWC_ST_CMD;
    else if (byte_done)
    begin
      unique case (state_q)
        FBWC_ST_CMD:    state_d = dec_ok ? FBWC_ST_ADDR : FBWC_ST_IGNORE;
        FBWC_ST_ADDR:   if (addr_last)
                          state_d = takes_data ? FBWC_ST_DATA : FBWC_ST_HOLD;
        FBWC_ST_IDLE,
        FBWC_ST_DATA,
        FBWC_ST_HOLD,
        FBWC_ST_IGNORE: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q    <= FBWC_ST_IDLE;
      sclk_q     <= 1'b1;
      csn_q      <= 1'b1;
      op_q       <= FBWC_OP_NONE;
      buf_q      <= 1'b0;
      byte_cnt_q <= 2'h0;
      addr_hi_q  <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      sclk_q  <= sclk_s;
      csn_q   <= csn_s;
      if (cs_fall)
        byte_cnt_q <= 2'h0;
      else if (byte_done && state_q == FBWC_ST_CMD)
      begin
        op_q  <= dec_op;
        buf_q <= dec_buf;
      end
      else if (byte_done && state_q == FBWC_ST_ADDR)
      begin
        byte_cnt_q <= byte_cnt_q + 2'h1;
        addr_hi_q  <= full_addr[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // buffer write pointer
  // ---------------------------------------------------------------
  logic [AW-1:0]          wptr_q;
  logic                   we_q;
  logic [AW-1:0]          waddr_q;
  logic [7:0]             wdata_q;
  logic [FBWC_ADDR_W-1:0] page_q;

  // page bits dropped, only the position inside the buffer is kept
  wire [AW-1:0] start_idx = AW'(full_addr % DEPTH);
  wire [AW-1:0] wptr_nxt  = (wptr_q == LAST_LOC) ? '0 : wptr_q + AW'(1);
  wire          data_byte = byte_done & (state_q == FBWC_ST_DATA);

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wptr_q  <= '0;
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 8'h00;
      page_q  <= '0;
    end
    else
    begin
      we_q <= data_byte;
      if (addr_last && state_q == FBWC_ST_ADDR)
      begin
        wptr_q <= start_idx;
        page_q <= full_addr;
      end
      else if (data_byte)
      begin
        waddr_q <= wptr_q;
        wdata_q <= new_byte;
        wptr_q  <= wptr_nxt;
      end
    end
  end

  fbwc_wr_if #(.AW(AW)) wr_bus ();

  assign wr_bus.we   = we_q;
  assign wr_bus.sel  = buf_q;
  assign wr_bus.addr = waddr_q;
  assign wr_bus.data = wdata_q;

  fbwc_buf #(
    .DEPTH     (DEPTH),
    .NBUF      (NBUF),
    .AW        (AW)
  ) u_buf (
    .clk_i     (sys_clk_i),
    .rst_ni    (resetn_i),
    .wr        (wr_bus),
    .rd_sel_i  (rd_sel_i),
    .rd_addr_i (rd_addr_i),
    .rd_data_o (rd_data_o)
  );

  // ---------------------------------------------------------------
  // operation launch and busy timer
  // ---------------------------------------------------------------
  logic [CW-1:0] busy_cnt_q;
  logic [7:0]    status_q;
  logic          op_valid_q;
  fbwc_op_t      op_kind_q;
  logic          op_buf_q;
  logic          miso_q;
  logic [FBWC_ADDR_W-1:0] op_addr_q;

  wire frame_ok   = (state_q == FBWC_ST_HOLD) | (state_q == FBWC_ST_DATA);
  wire is_erase   = (op_q == FBWC_OP_PROG_ERASE) | (op_q == FBWC_OP_PROG_THRU)
                  | (op_q == FBWC_OP_REWRITE);
  wire is_prog    = (op_q == FBWC_OP_PROG);
  wire launch     = cs_rise & frame_ok & (op_q != FBWC_OP_BUF_WR)
                  & status_q[FBWC_READY_BIT];
  wire start_busy = launch & (is_erase | is_prog);
  wire [CW-1:0] busy_load = is_prog ? PP_LOAD : PEP_LOAD;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_cnt_q <= '0;
      status_q   <= FBWC_STATUS_RST;
    end
    else if (start_busy)
    begin
      busy_cnt_q <= busy_load;
      status_q[FBWC_READY_BIT] <= 1'b0;
    end
    else if (busy_cnt_q != '0)
    begin
      busy_cnt_q <= busy_cnt_q - CNT_ONE;
      if (busy_cnt_q == CNT_ONE)
        status_q[FBWC_READY_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      op_valid_q <= 1'b0;
      op_kind_q  <= FBWC_OP_NONE;
      op_buf_q   <= 1'b0;
      op_addr_q  <= '0;
      miso_q     <= 1'b1;
    end
    else
    begin
      op_valid_q <= launch;
      miso_q     <= 1'b1;                          // idles high, no read commands
      if (launch)
      begin
        op_kind_q <= op_q;
        op_buf_q  <= buf_q;
        op_addr_q <= page_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign miso_o     = miso_q;
  assign status_o   = status_q;
  assign op_valid_o = op_valid_q;
  assign op_kind_o  = op_kind_q;
  assign op_buf_o   = op_buf_q;
  assign op_addr_o  = op_addr_q;

endmodule

// >>> rtl/fbwc_pkg.sv
// constants and types of the flash buffer write command front end
package fbwc_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FBWC_CMD_WR_B1   = 8'h84;
  localparam logic [7:0] FBWC_CMD_WR_B2   = 8'h87;
  localparam logic [7:0] FBWC_CMD_PEP_B1  = 8'h83;
  localparam logic [7:0] FBWC_CMD_PEP_B2  = 8'h86;
  localparam logic [7:0] FBWC_CMD_PP_B1   = 8'h88;
  localparam logic [7:0] FBWC_CMD_PP_B2   = 8'h89;
  localparam logic [7:0] FBWC_CMD_PTB_B1  = 8'h82;
  localparam logic [7:0] FBWC_CMD_PTB_B2  = 8'h85;
  localparam logic [7:0] FBWC_CMD_CMP_B1  = 8'h60;
  localparam logic [7:0] FBWC_CMD_CMP_B2  = 8'h61;
  localparam logic [7:0] FBWC_CMD_RW_B1   = 8'h58;
  localparam logic [7:0] FBWC_CMD_RW_B2   = 8'h59;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int         FBWC_BYTE_W      = 8;
  localparam int         FBWC_ADDR_W      = 24;
  localparam logic [1:0] FBWC_LAST_ADDR   = 2'h2;
  localparam logic [2:0] FBWC_LAST_BIT    = 3'h7;
  localparam int         FBWC_READY_BIT   = 7;
  localparam int         FBWC_BUF_DEPTH   = 256;
  localparam int         FBWC_NUM_BUF     = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] FBWC_SYNC_RST    = 3'h6;
  localparam logic [7:0] FBWC_STATUS_RST  = 8'h80;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int FBWC_CLK_MHZ       = 100;
  localparam int FBWC_LINK_MAX_MHZ  = 66;
  localparam int FBWC_T_PEP_MS      = 35;
  localparam int FBWC_T_PP_MS       = 4;
  localparam int FBWC_PEP_CYCLES    = FBWC_T_PEP_MS * 1000 * FBWC_CLK_MHZ;
  localparam int FBWC_PP_CYCLES     = FBWC_T_PP_MS * 1000 * FBWC_CLK_MHZ;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FBWC_OP_NONE,
    FBWC_OP_BUF_WR,
    FBWC_OP_PROG_ERASE,
    FBWC_OP_PROG,
    FBWC_OP_PROG_THRU,
    FBWC_OP_COMPARE,
    FBWC_OP_REWRITE
  } fbwc_op_t;

  typedef enum {
    FBWC_ST_IDLE,
    FBWC_ST_CMD,
    FBWC_ST_ADDR,
    FBWC_ST_DATA,
    FBWC_ST_HOLD,
    FBWC_ST_IGNORE
  } fbwc_state_t;

endpackage

// >>> rtl/fbwc_wr_if.sv
// byte write port between the command front end and the page buffers
interface fbwc_wr_if #(
  parameter int AW = 8
);
  logic          we;
  logic          sel;
  logic [AW-1:0] addr;
  logic [7:0]    data;

  modport src (output we, sel, addr, data);
  modport dst (input  we, sel, addr, data);
endinterface

// >>> rtl/fbwc_sync.sv
// two flop synchroniser, one chain per bit
module fbwc_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_ni,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i or negedge rst_ni)
      begin
        if (!rst_ni)
        begin
          meta_q <= RST_VAL[g];
          sync_q <= RST_VAL[g];
        end
        else
        begin
          meta_q <= d_i[g];
          sync_q <= meta_q;
        end
      end
      assign q_o[g] = sync_q;
    end
  endgenerate

endmodule

// >>> rtl/fbwc_buf.sv
// sram page buffers held in flip-flops, one bank per buffer
module fbwc_buf #(
  parameter int DEPTH = 256,
  parameter int NBUF  = 2,
  parameter int AW    = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_ni,
  // write side
  fbwc_wr_if.dst             wr,
  // read side
  input  wire logic          rd_sel_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [7:0]    rd_data_o
);

  logic [7:0] mem [NBUF][DEPTH];
  logic [7:0] rd_q;
  wire        rd_bank = (NBUF > 1) ? rd_sel_i : 1'b0;

  genvar b;
  generate
    for (b = 0; b < NBUF; b++)
    begin : g_bank
      wire hit = wr.we && (wr.sel == 1'(b));
      always_ff @(posedge clk_i)
      begin
        if (hit)
          mem[b][wr.addr] <= wr.data;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      rd_q <= 8'h00;
    else
      rd_q <= mem[rd_bank][rd_addr_i];
  end

  assign rd_data_o = rd_q;

endmodule

// >>> test/fbwc_chk_assertions.sv
// port assertions for the flash buffer write front end
module fbwc_chk
  import fbwc_pkg::*;
#(
  parameter int NBUF       = 2,
  parameter int PEP_CYCLES = 20,
  parameter int PP_CYCLES  = 10,
  parameter int AW         = 8
) (
  // clock and reset
  input wire logic               sys_clk_i,
  input wire logic               resetn_i,
  // link
  input wire logic               spi_clk_i,
  input wire logic               chip_select_low_i,
  input wire logic               mosi_i,
  input wire logic               miso_o,
  // status and launch
  input wire logic [7:0]         status_o,
  input wire logic               op_valid_o,
  input wire fbwc_pkg::fbwc_op_t op_kind_o,
  input wire logic               op_buf_o,
  input wire logic [23:0]        op_addr_o,
  // read port
  input wire logic               rd_sel_i,
  input wire logic [AW-1:0]      rd_addr_i,
  input wire logic [7:0]         rd_data_o
);
  // ----
  // busy length
  // ----
  int busy_cnt_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i) busy_cnt_q <= 0;
    else if (status_o[7]) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // ----
  // properties
  // ----
  property p_pulse; op_valid_o |=> !op_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("launch longer than one cycle");
  property p_kind;
    op_valid_o |-> op_kind_o inside {FBWC_OP_PROG_ERASE, FBWC_OP_PROG,
                                     FBWC_OP_PROG_THRU, FBWC_OP_COMPARE, FBWC_OP_REWRITE};
  endproperty
  a_kind: assert property (p_kind) else $error("bad launch kind");
  property p_busy_start; op_valid_o && op_kind_o != FBWC_OP_COMPARE |-> !status_o[7]; endproperty
  a_busy_start: assert property (p_busy_start) else $error("no busy on launch");
  property p_busy_cause; $fell(status_o[7]) |-> op_valid_o; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without launch");
  property p_compare; op_valid_o && op_kind_o == FBWC_OP_COMPARE |-> status_o[7]; endproperty
  a_compare: assert property (p_compare) else $error("compare made busy");
  property p_busy_max; busy_cnt_q <= PEP_CYCLES + 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_min; $rose(status_o[7]) |-> busy_cnt_q >= PP_CYCLES - 1; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_held;
    !op_valid_o |-> $stable(op_kind_o) && $stable(op_buf_o) && $stable(op_addr_o);
  endproperty
  a_held: assert property (p_held) else $error("launch fields moved");
  property p_single; op_valid_o |-> NBUF > 1 || !op_buf_o; endproperty
  a_single: assert property (p_single) else $error("second buffer on single variant");
  c_buf2: cover property (op_valid_o && op_buf_o);
  c_done: cover property ($rose(status_o[7]));
  c_cmp: cover property (op_valid_o && op_kind_o == FBWC_OP_COMPARE);
endmodule

bind fbwc_top fbwc_chk #(.NBUF(NBUF), .PEP_CYCLES(PEP_CYCLES), .PP_CYCLES(PP_CYCLES), .AW(AW))
  fbwc_chk_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi_clk_i(spi_clk_i),
    .chip_select_low_i(chip_select_low_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .status_o(status_o), .op_valid_o(op_valid_o), .op_kind_o(op_kind_o),
    .op_buf_o(op_buf_o), .op_addr_o(op_addr_o), .rd_sel_i(rd_sel_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o));

// >>> test/fbwc_master.sv
// serial master model driving the link
module fbwc_master (
  // serial link
  output logic spi_clk_o,
  output logic chip_select_low_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 40ns;

  initial
  begin
    spi_clk_o = 1'b1;
    chip_select_low_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic start_frame();
    chip_select_low_o = 1'b0;
    #HALF;
  endtask

  task automatic shift_bit(input logic b);
    spi_clk_o = 1'b0;
    mosi_o = b;
    #HALF;
    spi_clk_o = 1'b1;
    #HALF;
  endtask

  task automatic shift8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) shift_bit(v[i]);
  endtask

  task automatic stop_frame();
    spi_clk_o = 1'b0;
    chip_select_low_o = 1'b1;
    mosi_o = ~mosi_o;
    #HALF;
    spi_clk_o = 1'b1;
    #(4 * HALF);
  endtask
endmodule

// >>> test/tb.sv
// self-checking bench of the flash buffer write front end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fbwc_pkg::*;
  localparam int PEP = 400;
  localparam int PP  = 200;
  logic        sys_clk_i, resetn_i, spi_clk, cs_low, mosi, rd_sel;
  logic        miso, op_valid, op_buf, op_valid1;
  logic [7:0]  rd_addr, status, rd_data;
  fbwc_op_t    op_kind;
  logic [23:0] op_addr;
  logic [31:0] seed;
  logic [7:0]  exp_mem [2][256];
  logic        known [2][256];
  logic [7:0]  dq [$];
  int          n_errors, check_count, n_launch, n_launch1, busy_len;
  fbwc_op_t    kinds [5] = '{FBWC_OP_PROG_ERASE, FBWC_OP_PROG, FBWC_OP_PROG_THRU,
                             FBWC_OP_COMPARE, FBWC_OP_REWRITE};
  logic [7:0]  codes [10] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85,
                              8'h60, 8'h61, 8'h58, 8'h59};
  int          busy [5] = '{PEP, PP, PEP, 0, PEP};

  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;

  fbwc_master fbwc_master_i (.spi_clk_o(spi_clk), .chip_select_low_o(cs_low), .mosi_o(mosi));
  fbwc_top #(.PEP_CYCLES(PEP), .PP_CYCLES(PP)) fbwc_top_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi_clk_i(spi_clk),
    .chip_select_low_i(cs_low), .mosi_i(mosi), .miso_o(miso), .status_o(status),
    .op_valid_o(op_valid), .op_kind_o(op_kind), .op_buf_o(op_buf), .op_addr_o(op_addr),
    .rd_sel_i(rd_sel), .rd_addr_i(rd_addr), .rd_data_o(rd_data));
  fbwc_top #(.NBUF(1), .PEP_CYCLES(PEP), .PP_CYCLES(PP)) fbwc_top_one_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi_clk_i(spi_clk),
    .chip_select_low_i(cs_low), .mosi_i(mosi), .miso_o(), .status_o(),
    .op_valid_o(op_valid1), .op_kind_o(), .op_buf_o(), .op_addr_o(),
    .rd_sel_i(1'b0), .rd_addr_i(rd_addr), .rd_data_o());

  // ----
  // launch monitor
  // ----
  always @(posedge sys_clk_i)
  begin
    if (op_valid1 === 1'b1) n_launch1++;
    if (op_valid === 1'b1)
    begin
      n_launch++;
      busy_len = 0;
    end
    if (status[7] === 1'b0) busy_len++;
  end

  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic fill(input int n);
    dq.delete();
    repeat (n) dq.push_back(rnd());
  endtask

  task automatic frame(input logic [7:0] cmd, input logic [23:0] adr, input int nd,
                       input int tail);
    logic b;
    b = (cmd == 8'h87) || (cmd == 8'h85);
    fbwc_master_i.start_frame();
    fbwc_master_i.shift8(cmd);
    for (int i = 2; i >= 0; i--) fbwc_master_i.shift8(adr[8*i +: 8]);
    for (int k = 0; k < nd; k++)
    begin
      fbwc_master_i.shift8(dq[k]);
      if (cmd inside {8'h84, 8'h87, 8'h82, 8'h85})
      begin
        exp_mem[b][adr[7:0] + k[7:0]] = dq[k];
        known[b][adr[7:0] + k[7:0]] = 1'b1;
      end
    end
    for (int k = 0; k < tail; k++) fbwc_master_i.shift_bit(rnd() > 8'h7f);
    fbwc_master_i.stop_frame();
  endtask

  task automatic verify();
    for (int b = 0; b < 2; b++)
      for (int a = 0; a < 256; a++)
        if (known[b][a] === 1'b1)
        begin
          rd_sel = b[0];
          rd_addr = a[7:0];
          @(negedge sys_clk_i);
          @(negedge sys_clk_i);
          check(rd_data, exp_mem[b][a]);
        end
  endtask

  task automatic wait_ready();
    for (int i = 0; i < PEP + 100 && status[7] !== 1'b1; i++) @(negedge sys_clk_i);
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    int n0;
    logic [23:0] adr;
    seed = 32'h35fd;
    resetn_i = 1'b0;
    rd_sel = 1'b0;
    rd_addr = 8'h00;
    repeat (5) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check(status, FBWC_STATUS_RST);
    check({miso, op_valid, op_buf, op_addr}, 32'h04000000);
    check(op_kind, FBWC_OP_NONE);
    fill(6);
    frame(8'h84, {rnd(), rnd(), 8'hfd}, 6, 0);
    fill(258);
    frame(8'h87, {rnd(), rnd(), 8'h02}, 258, 0);
    fill(4);
    frame(8'h84, 24'h000010, 4, 0);
    fill(2);
    frame(8'h84, 24'h000010, 2, 5);
    fill(3);
    frame(8'h00, 24'h000010, 3, 0);
    frame(8'hff, 24'h000011, 3, 0);
    verify();
    check(n_launch, 0);
    for (int i = 0; i < 10; i++)
    begin
      n0 = n_launch;
      adr = {rnd(), rnd(), rnd()};
      fill(3);
      frame(codes[i], adr, (i / 2 == 2) ? 3 : 0, 0);
      check(n_launch, n0 + 1);
      check(op_kind, kinds[i / 2]);
      check(op_buf, i % 2);
      check(op_addr, adr);
      wait_ready();
      check(busy_len >= busy[i / 2] - 1 && busy_len <= busy[i / 2] + 1, 1);
    end
    frame(8'h83, 24'h000100, 0, 0);
    n0 = n_launch;
    frame(8'h88, 24'h000200, 0, 0);
    wait_ready();
    check(n_launch, n0);
    check(op_kind, FBWC_OP_PROG_ERASE);
    verify();
    check(n_launch1, 6);
    print_verdict();
  end

  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    n_errors++;
    print_verdict();
  end
endmodule
